/* File: core/dma_irq_pkg.sv */
// constants for the dma configuration and interrupt flag block
// assumes a 100 MHz core clock and a byte-wide command decoder in front
package dma_irq_pkg;
    // command codes
    localparam logic [7:0] CMD_SET_DMA = 8'h00_FB;
    localparam logic [7:0] CMD_READ_IRQ = 8'h00_F4;
    localparam logic [7:0] CMD_LAST_STATUS = 8'h00_40;
    localparam logic [7:0] CMD_GROUP_MASK = 8'h00_F0;
    localparam logic [3:0] EP_COUNT = 4'h0_6;
    // configuration byte fields
    localparam int CFG_BURST_LSB = 0;
    localparam int CFG_BURST_MSB = 1;
    localparam int CFG_ENABLE = 2;
    localparam int CFG_DIRECTION = 3;
    localparam int CFG_AUTO_RELOAD = 4;
    localparam int CFG_PIN_MODE = 5;
    localparam int CFG_EP4_IRQ_EN = 6;
    localparam int CFG_EP5_IRQ_EN = 7;
    localparam logic [7:0] CFG_RESET = 8'h00_00;
    // burst codes
    localparam logic [1:0] BURST_SINGLE = 2'h0;
    localparam logic [1:0] BURST_FOUR = 2'h1;
    localparam logic [1:0] BURST_EIGHT = 2'h2;
    localparam logic [1:0] BURST_SIXTEEN = 2'h3;
    // status byte one fields
    localparam int ST_EP_MSB = 5;
    localparam int ST_EP4 = 4;
    localparam int ST_EP5 = 5;
    localparam int ST_BUS_RESET = 6;
    localparam int ST_SUSPEND_CHG = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00_00;
    // suspend detection timing
    localparam int CLK_MHZ = 100;
    localparam int FRAME_TIME_US = 1000;
    localparam int FRAME_CYCLES = FRAME_TIME_US * CLK_MHZ;
    localparam logic [1:0] MISSED_FRAMES_SUSPEND = 2'h3;

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_DMA,
        CMD_IRQ,
        CMD_OTHER
    } cmd_state_e;
endpackage : dma_irq_pkg

/* File: core/dma_irq_flags.sv */
// dma configuration byte, interrupt status bytes and interrupt pin logic
// assumes a command decoder that hands over command and data strobes on clk_in
//
// Behaviour
// [R1] command FBh reaches the dma configuration; one data byte written or read follows
// [R2] configuration bits 1:0 select single, four, eight or sixteen cycle bursts
// [R3] bit 2 enables dma; hardware clears it when transfer end is asserted
// [R4] bit 3 selects direction: 0 out buffer to memory, 1 memory to in buffer
// [R5] bit 4 set restarts dma automatically after each finished transfer
// [R6] bit 5 set: interrupt on every start of frame or any status bit
// [R7] bit 5 clear: interrupt only while some status bit is set
// [R8] bit 6 clear keeps endpoint index four from causing an interrupt
// [R9] bit 7 clear keeps endpoint index five from causing an interrupt
// [R10] software should disable endpoint four and five interrupts while dma runs
// [R11] command F4h reads status byte one, optionally followed by byte two
// [R12] status bits 0..5 flag control out/in, ep1 out/in, ep2 out/in
// [R13] endpoint flags clear only by their last transaction status command
// [R14] status bit 6 sets on bus reset, clears when status is read
// [R15] status bit 7 sets on suspend entry or resume, clears on read
// [R16] byte two bit 0 sets on dma transfer end, clears when read
// [R17] start of frame only mode limits the interrupt to start of frame events
// [R18] commands 40h..45h clear the flag of endpoint given by low nibble
// [R19] interrupt drops once no flag and no start of frame event pends
`timescale 1ns/1ps
module dma_irq_flags
    import dma_irq_pkg::*;
#(
    parameter int FRAME_CYCLES_P = FRAME_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_strobe_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic wr_strobe_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_strobe_in,
    input wire logic [5:0] ep_event_in,
    input wire logic bus_reset_in,
    input wire logic sof_in,
    input wire logic sof_only_in,
    input wire logic transfer_end_in_low,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic [1:0] burst_out,
    output logic dma_enable_out,
    output logic direction_out,
    output logic suspended_out,
    output logic irq_out
);

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] stat_lo;
        logic stat_hi;
        logic sof_pend;
        cmd_state_e cmd;
        logic second;
        logic [7:0] rd_data;
        logic rd_valid;
        logic irq;
        logic [2:0] sync;
        logic eot_lvl;
        logic restart_pend;
        logic [31:0] frame_cnt;
        logic [1:0] missed;
        logic suspended;
    } state_s;

    localparam state_s STATE_RESET = '{
        cfg: CFG_RESET,
        stat_lo: STATUS_RESET,
        stat_hi: 1'b0,
        sof_pend: 1'b0,
        cmd: CMD_NONE,
        second: 1'b0,
        rd_data: 8'h00_00,
        rd_valid: 1'b0,
        irq: 1'b0,
        sync: 3'h7,
        eot_lvl: 1'b1,
        restart_pend: 1'b0,
        frame_cnt: 32'h0000_0000,
        missed: 2'h0,
        suspended: 1'b0
    };

    state_s state_reg;
    state_s state_next;

    // status bits that may drive the pin, with ep4/ep5 gated by the config
    function automatic logic [7:0] irq_sources(input logic [7:0] stat, input logic [7:0] cfg);
        logic [7:0] g;
        g = stat;
        g[ST_EP4] = stat[ST_EP4] & cfg[CFG_EP4_IRQ_EN]; // see [R8]
        g[ST_EP5] = stat[ST_EP5] & cfg[CFG_EP5_IRQ_EN]; // see [R9]
        return g;
    endfunction : irq_sources

    logic eot_fall;
    logic frame_tick;
    logic [7:0] clr_lo;
    logic clr_hi;
    logic clr_sof;
    logic [7:0] set_lo;

    always_comb begin
        state_next = state_reg;
        eot_fall = 1'b0;
        frame_tick = 1'b0;
        clr_lo = 8'h00_00;
        clr_hi = 1'b0;
        clr_sof = 1'b0;
        set_lo = 8'h00_00;
        state_next.rd_valid = 1'b0;

        // pin synchroniser; level follows once stages two and three agree
        state_next.sync = {state_reg.sync[1:0], transfer_end_in_low};
        if (state_reg.sync[1] == state_reg.sync[2]) begin
            state_next.eot_lvl = state_reg.sync[2];
        end
        eot_fall = state_reg.eot_lvl && (state_reg.sync[1] == state_reg.sync[2])
            && !state_reg.sync[2];

        // command phase
        if (cmd_strobe_in) begin
            state_next.second = 1'b0;
            if (cmd_code_in == CMD_SET_DMA) begin
                state_next.cmd = CMD_DMA; // see [R1]
            end else if (cmd_code_in == CMD_READ_IRQ) begin
                state_next.cmd = CMD_IRQ; // see [R11]
            end else begin
                state_next.cmd = CMD_OTHER;
                if ((cmd_code_in & CMD_GROUP_MASK) == CMD_LAST_STATUS
                        && cmd_code_in[3:0] < EP_COUNT) begin
                    clr_lo[cmd_code_in[2:0]] = 1'b1; // see [R13] [R18]
                end
            end
        end else if (wr_strobe_in && state_reg.cmd == CMD_DMA) begin
            // one byte only; further bytes are ignored
            state_next.cfg = wr_data_in; // see [R1] [R2] [R4]
            state_next.cmd = CMD_NONE;
        end else if (rd_strobe_in) begin
            state_next.rd_valid = 1'b1;
            state_next.rd_data = 8'h00_00;
            unique case (state_reg.cmd)
                CMD_DMA: begin
                    state_next.rd_data = state_reg.cfg; // see [R1]
                    state_next.cmd = CMD_NONE;
                end
                CMD_IRQ: begin
                    if (!state_reg.second) begin
                        state_next.rd_data = state_reg.stat_lo; // see [R11]
                        clr_lo[ST_BUS_RESET] = 1'b1; // see [R14]
                        clr_lo[ST_SUSPEND_CHG] = 1'b1; // see [R15]
                        clr_sof = 1'b1;
                        state_next.second = 1'b1;
                    end else begin
                        state_next.rd_data = {7'h00, state_reg.stat_hi};
                        clr_hi = 1'b1; // see [R16]
                        state_next.cmd = CMD_NONE;
                    end
                end
                CMD_NONE, CMD_OTHER: begin
                    state_next.rd_data = 8'h00_00;
                end
            endcase
        end

        // suspend detection: three frame times without a start of frame
        if (state_reg.frame_cnt >= 32'(FRAME_CYCLES_P - 1) || sof_in || bus_reset_in) begin
            state_next.frame_cnt = 32'h0000_0000;
            frame_tick = !(sof_in || bus_reset_in);
        end else begin
            state_next.frame_cnt = state_reg.frame_cnt + 32'h0000_0001;
        end
        if (sof_in || bus_reset_in) begin
            state_next.missed = 2'h0;
            if (state_reg.suspended) begin
                state_next.suspended = 1'b0;
                set_lo[ST_SUSPEND_CHG] = 1'b1; // see [R15]
            end
        end else if (frame_tick && !state_reg.suspended) begin
            if (state_reg.missed == MISSED_FRAMES_SUSPEND - 2'h1) begin
                state_next.suspended = 1'b1;
                state_next.missed = 2'h0;
                set_lo[ST_SUSPEND_CHG] = 1'b1; // see [R15]
            end else begin
                state_next.missed = state_reg.missed + 2'h1;
            end
        end

        set_lo[ST_EP_MSB:0] = ep_event_in; // see [R12]
        set_lo[ST_BUS_RESET] = bus_reset_in; // see [R14]
        // set wins over a clear in the same cycle
        state_next.stat_lo = (state_reg.stat_lo & ~clr_lo) | set_lo;
        state_next.stat_hi = (state_reg.stat_hi & ~clr_hi) | eot_fall; // see [R16]
        state_next.sof_pend = (state_reg.sof_pend & ~clr_sof) | sof_in;

        // transfer end clears enable; auto reload sets it again a cycle later
        state_next.restart_pend = 1'b0;
        if (eot_fall) begin
            state_next.cfg[CFG_ENABLE] = 1'b0; // see [R3]
            state_next.restart_pend = state_reg.cfg[CFG_AUTO_RELOAD]; // see [R5]
        end else if (state_reg.restart_pend) begin
            state_next.cfg[CFG_ENABLE] = 1'b1; // see [R5]
        end

        // interrupt pin, from the flags as they stand this cycle
        if (sof_only_in) begin
            state_next.irq = state_reg.sof_pend; // see [R17]
        end else if (state_reg.cfg[CFG_PIN_MODE]) begin
            state_next.irq = state_reg.sof_pend
                || |irq_sources(state_reg.stat_lo, state_reg.cfg)
                || state_reg.stat_hi; // see [R6] [R19]
        end else begin
            state_next.irq = |irq_sources(state_reg.stat_lo, state_reg.cfg)
                || state_reg.stat_hi; // see [R7] [R19]
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data_out = state_reg.rd_data;
    assign rd_valid_out = state_reg.rd_valid;
    assign burst_out = state_reg.cfg[CFG_BURST_MSB:CFG_BURST_LSB];
    assign dma_enable_out = state_reg.cfg[CFG_ENABLE];
    assign direction_out = state_reg.cfg[CFG_DIRECTION];
    assign suspended_out = state_reg.suspended;
    assign irq_out = state_reg.irq;

    // assertions
    sequence s_cfg_cmd;
        cmd_strobe_in && cmd_code_in == CMD_SET_DMA;
    endsequence

    sequence s_cfg_write;
        wr_strobe_in && !cmd_strobe_in;
    endsequence

    property p_cfg_write;
        @(posedge clk_in) disable iff (rst_in)
        s_cfg_cmd ##1 (s_cfg_write and (!eot_fall && !state_reg.restart_pend))
            |=> burst_out == $past(wr_data_in[1:0]) && direction_out == $past(wr_data_in[3]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write not taken"); // see [R1]

    property p_cfg_read;
        @(posedge clk_in) disable iff (rst_in)
        s_cfg_cmd ##1 (rd_strobe_in && !cmd_strobe_in)
            |=> rd_valid_out && rd_data_out == $past(state_reg.cfg);
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read wrong"); // see [R1]

    property p_eot_clears;
        @(posedge clk_in) disable iff (rst_in)
        eot_fall |=> !dma_enable_out && state_reg.stat_hi;
    endproperty
    a_eot_clears: assert property (p_eot_clears) else $error("enable not cleared on end"); // see [R3]

    property p_auto_reload;
        @(posedge clk_in) disable iff (rst_in)
        eot_fall && state_reg.cfg[CFG_AUTO_RELOAD] && !cmd_strobe_in ##1 !eot_fall
            |=> dma_enable_out;
    endproperty
    a_auto_reload: assert property (p_auto_reload) else $error("no automatic restart"); // see [R5]

    property p_pin_normal;
        @(posedge clk_in) disable iff (rst_in)
        !sof_only_in && !state_reg.cfg[CFG_PIN_MODE]
            |=> irq_out == ($past(|irq_sources(state_reg.stat_lo, state_reg.cfg))
                || $past(state_reg.stat_hi));
    endproperty
    a_pin_normal: assert property (p_pin_normal) else $error("pin mode 0 wrong"); // see [R7]

    property p_pin_sof;
        @(posedge clk_in) disable iff (rst_in)
        sof_in && !sof_only_in ##1 (state_reg.cfg[CFG_PIN_MODE] && !sof_only_in)
            |=> irq_out;
    endproperty
    a_pin_sof: assert property (p_pin_sof) else $error("sof did not raise pin"); // see [R6]

    property p_ep4_gate;
        @(posedge clk_in) disable iff (rst_in)
        !sof_only_in && !state_reg.cfg[CFG_PIN_MODE] && !state_reg.cfg[CFG_EP4_IRQ_EN]
            && state_reg.stat_lo == 8'h00_10 && !state_reg.stat_hi |=> !irq_out;
    endproperty
    a_ep4_gate: assert property (p_ep4_gate) else $error("ep4 interrupt not gated"); // see [R8]

    property p_ep5_gate;
        @(posedge clk_in) disable iff (rst_in)
        !sof_only_in && !state_reg.cfg[CFG_PIN_MODE] && !state_reg.cfg[CFG_EP5_IRQ_EN]
            && state_reg.stat_lo == 8'h00_20 && !state_reg.stat_hi |=> !irq_out;
    endproperty
    a_ep5_gate: assert property (p_ep5_gate) else $error("ep5 interrupt not gated"); // see [R9]

    property p_ep_sticky;
        @(posedge clk_in) disable iff (rst_in)
        state_reg.stat_lo[0] && !(cmd_strobe_in && cmd_code_in == CMD_LAST_STATUS)
            |=> state_reg.stat_lo[0];
    endproperty
    a_ep_sticky: assert property (p_ep_sticky) else $error("ep flag lost"); // see [R13]

    property p_status_read;
        @(posedge clk_in) disable iff (rst_in)
        cmd_strobe_in && cmd_code_in == CMD_READ_IRQ ##1 (rd_strobe_in && !cmd_strobe_in
            && !bus_reset_in) |=> rd_valid_out && !state_reg.stat_lo[ST_BUS_RESET];
    endproperty
    a_status_read: assert property (p_status_read) else $error("bus reset not cleared"); // see [R14]

    property p_sof_only;
        @(posedge clk_in) disable iff (rst_in)
        sof_only_in && !state_reg.sof_pend |=> !irq_out;
    endproperty
    a_sof_only: assert property (p_sof_only) else $error("sof only mode leaked"); // see [R17]

    property p_last_status;
        @(posedge clk_in) disable iff (rst_in)
        cmd_strobe_in && cmd_code_in == 8'h00_42 && !ep_event_in[2]
            |=> !state_reg.stat_lo[2];
    endproperty
    a_last_status: assert property (p_last_status) else $error("ep flag not cleared"); // see [R18]

    // a data byte after the read interrupt command F4h must leave the config alone
    property p_write_refused;
        @(posedge clk_in) disable iff (rst_in)
        cmd_strobe_in && cmd_code_in == CMD_READ_IRQ ##1 (wr_strobe_in && !cmd_strobe_in
            && !eot_fall && !state_reg.restart_pend) |=> $stable(state_reg.cfg);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("stray write taken"); // see [R1]

    property p_done_read;
        @(posedge clk_in) disable iff (rst_in)
        rd_strobe_in && !cmd_strobe_in && state_reg.cmd == CMD_IRQ && state_reg.second
            && !eot_fall |=> rd_valid_out && !state_reg.stat_hi;
    endproperty
    a_done_read: assert property (p_done_read) else $error("end flag not cleared"); // see [R16]

    property p_resume;
        @(posedge clk_in) disable iff (rst_in)
        state_reg.suspended && sof_in |=> !suspended_out && state_reg.stat_lo[ST_SUSPEND_CHG];
    endproperty
    a_resume: assert property (p_resume) else $error("resume not flagged"); // see [R15]

endmodule : dma_irq_flags

/* File: bench/host_model.sv */
// microcontroller model on the command bus: command, write and read strobes
// assumes its tasks are called just after a rising edge of clk_in
`timescale 1ns/1ps
module host_model (
    input wire logic clk_in,
    output logic cmd_strobe_out,
    output logic [7:0] cmd_code_out,
    output logic wr_strobe_out,
    output logic [7:0] wr_data_out,
    output logic rd_strobe_out
);
    int slow = 0;
    int last = 0;

    initial begin
        cmd_strobe_out = 1'b0;
        cmd_code_out = 8'h00;
        wr_strobe_out = 1'b0;
        wr_data_out = 8'h00;
        rd_strobe_out = 1'b0;
    end

    // slow host: idle cycles after each strobe
    task automatic gap();
        repeat (slow) @(posedge clk_in);
    endtask : gap

    // same strobe twice running: an edge passes so it is never raised as it drops
    task automatic space(input int kind);
        if (slow == 0 && last == kind) begin
            @(posedge clk_in);
        end
        last = kind;
    endtask : space

    // released bytes show the inverse, never a stale copy
    task automatic cmd(input logic [7:0] code);
        space(1);
        cmd_strobe_out <= 1'b1;
        cmd_code_out <= code;
        @(posedge clk_in);
        cmd_strobe_out <= 1'b0;
        cmd_code_out <= ~code;
        gap();
    endtask : cmd

    task automatic wr(input logic [7:0] data);
        space(2);
        wr_strobe_out <= 1'b1;
        wr_data_out <= data;
        @(posedge clk_in);
        wr_strobe_out <= 1'b0;
        wr_data_out <= ~data;
        gap();
    endtask : wr

    task automatic rd();
        space(3);
        rd_strobe_out <= 1'b1;
        @(posedge clk_in);
        rd_strobe_out <= 1'b0;
        gap();
    endtask : rd
endmodule : host_model

/* File: bench/tb.sv */
// self-checking bench for the dma configuration and interrupt flag block
// assumes host_model drives the command bus; frames shortened to 100 cycles
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end
module tb;
    import dma_irq_pkg::*;
    localparam int FRAME = 100;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] ep_event;
    logic bus_reset, sof, sof_only, eot_low, sof_run, sof_kick;
    logic cmd_stb, wr_stb, rd_stb, rd_valid_out, dma_enable_out, direction_out;
    logic suspended_out, irq_out;
    logic [7:0] cmd_code, wr_data, rd_data_out, cfg, exp_b;
    logic [1:0] burst_out;
    logic [31:0] rnd;
    logic [7:0] exp_q[$];
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;

    host_model host_model_inst (.clk_in(clk_in), .cmd_strobe_out(cmd_stb),
        .cmd_code_out(cmd_code), .wr_strobe_out(wr_stb), .wr_data_out(wr_data),
        .rd_strobe_out(rd_stb));
    dma_irq_flags #(.FRAME_CYCLES_P(FRAME)) dma_irq_flags_inst (.clk_in(clk_in),
        .rst_in(rst_in), .cmd_strobe_in(cmd_stb), .cmd_code_in(cmd_code),
        .wr_strobe_in(wr_stb), .wr_data_in(wr_data), .rd_strobe_in(rd_stb),
        .ep_event_in(ep_event), .bus_reset_in(bus_reset), .sof_in(sof),
        .sof_only_in(sof_only), .transfer_end_in_low(eot_low), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .burst_out(burst_out), .dma_enable_out(dma_enable_out),
        .direction_out(direction_out), .suspended_out(suspended_out), .irq_out(irq_out));

    always #5 clk_in = ~clk_in;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic end_sim();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // background frames keep the block out of suspend
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        sof <= (sof_run && cyc[5:0] == 6'h00) || sof_kick;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    always @(posedge clk_in) begin
        if (rd_valid_out === 1'b1) begin
            exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHK("read byte", exp_b, rd_data_out)
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    task automatic wcfg(input logic [7:0] v);
        host_model_inst.cmd(CMD_SET_DMA);
        host_model_inst.wr(v);
        tick(2);
    endtask : wcfg

    task automatic rcfg(input logic [7:0] v);
        exp_q.push_back(v);
        host_model_inst.cmd(CMD_SET_DMA);
        host_model_inst.rd();
    endtask : rcfg

    task automatic rirq(input logic [7:0] b1, input logic [7:0] b2, input logic two);
        exp_q.push_back(b1);
        host_model_inst.cmd(CMD_READ_IRQ);
        host_model_inst.rd();
        if (two) begin
            exp_q.push_back(b2);
            host_model_inst.rd();
        end
        tick(3);
    endtask : rirq

    task automatic pulse(input logic [5:0] ep, input logic br);
        ep_event <= ep;
        bus_reset <= br;
        tick(1);
        ep_event <= 6'h00;
        bus_reset <= 1'b0;
        tick(3);
    endtask : pulse

    task automatic kick();
        sof_kick <= 1'b1;
        tick(1);
        sof_kick <= 1'b0;
        tick(3);
    endtask : kick

    task automatic eot();
        eot_low <= 1'b0;
        tick(4);
        eot_low <= 1'b1;
        tick(4);
    endtask : eot

    initial begin
        rnd = 32'h0000_68bb;
        ep_event <= 6'h00;
        bus_reset <= 1'b0;
        sof_only <= 1'b0;
        eot_low <= 1'b1;
        sof_run <= 1'b1;
        sof_kick <= 1'b0;
        tick(20);
        rst_in <= 1'b0;
        tick(2);
        rcfg(CFG_RESET);
        rirq(STATUS_RESET, 8'h00, 1'b1);
        host_model_inst.cmd(CMD_READ_IRQ);
        host_model_inst.wr(8'hFF);
        rcfg(CFG_RESET);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            cfg = {rnd[7:2], k[1:0]};
            cfg[7:6] = cfg[2] ? 2'b00 : cfg[7:6];
            host_model_inst.slow = k;
            wcfg(cfg);
            `CHK("burst", cfg[1:0], burst_out)
            `CHK("enable", cfg[2], dma_enable_out)
            `CHK("direction", cfg[3], direction_out)
            rcfg(cfg);
        end
        host_model_inst.slow = 0;
        for (int i = 0; i < 6; i++) begin
            wcfg(8'h00);
            pulse(6'h01 << i, 1'b0);
            `CHK("irq gated", (i < 4), irq_out)
            wcfg(8'hC0);
            `CHK("irq ep", 1'b1, irq_out)
            rirq(8'h01 << i, 8'h00, 1'b0);
            rirq(8'h01 << i, 8'h00, 1'b0);
            host_model_inst.cmd(CMD_LAST_STATUS | i[7:0]);
            tick(3);
            `CHK("irq cleared", 1'b0, irq_out)
        end
        wcfg(8'h00);
        pulse(6'h00, 1'b1);
        `CHK("irq bus reset", 1'b1, irq_out)
        rirq(8'h40, 8'h00, 1'b1);
        rirq(8'h00, 8'h00, 1'b1);
        `CHK("irq idle", 1'b0, irq_out)
        wcfg(8'h05);
        eot();
        `CHK("enable end", 1'b0, dma_enable_out)
        `CHK("irq end", 1'b1, irq_out)
        rcfg(8'h01);
        rirq(8'h00, 8'h01, 1'b1);
        rirq(8'h00, 8'h00, 1'b1);
        wcfg(8'h16);
        eot();
        `CHK("enable reload", 1'b1, dma_enable_out)
        rirq(8'h00, 8'h01, 1'b1);
        // frames stopped so each start of frame below is a single known event
        sof_run <= 1'b0;
        wcfg(8'h20);
        rirq(8'h00, 8'h00, 1'b0);
        `CHK("irq no sof", 1'b0, irq_out)
        kick();
        `CHK("irq sof mode", 1'b1, irq_out)
        rirq(8'h00, 8'h00, 1'b0);
        `CHK("irq sof read", 1'b0, irq_out)
        wcfg(8'h00);
        kick();
        `CHK("irq normal sof", 1'b0, irq_out)
        sof_only <= 1'b1;
        wcfg(8'h20);
        rirq(8'h00, 8'h00, 1'b0);
        pulse(6'h00, 1'b1);
        `CHK("irq sof only", 1'b0, irq_out)
        kick();
        `CHK("irq sof only sof", 1'b1, irq_out)
        rirq(8'h40, 8'h00, 1'b0);
        sof_only <= 1'b0;
        wcfg(8'h00);
        `CHK("irq off", 1'b0, irq_out)
        tick(3 * FRAME + 50);
        `CHK("suspended", 1'b1, suspended_out)
        rirq(8'h80, 8'h00, 1'b0);
        rirq(8'h00, 8'h00, 1'b0);
        kick();
        `CHK("resumed", 1'b0, suspended_out)
        rirq(8'h80, 8'h00, 1'b0);
        `CHK("irq final", 1'b0, irq_out)
        tick(5);
        `CHK("reads left", 0, exp_q.size())
        end_sim();
    end
endmodule : tb
